// *** atsc_regs.svh ***
`ifndef ATSC_REGS_SVH
`define ATSC_REGS_SVH
// register byte addresses
`define ATSC_ADDR_CTRL     8'h00
`define ATSC_ADDR_TRIG     8'h04
`define ATSC_ADDR_ALEVEL   8'h08
`define ATSC_ADDR_PATTERN  8'h0C
`define ATSC_ADDR_MASK     8'h10
`define ATSC_ADDR_CLEVEL   8'h14
`define ATSC_ADDR_CHIGH    8'h18
`define ATSC_ADDR_PRECNT   8'h1C
`define ATSC_ADDR_DIV      8'h20
`define ATSC_ADDR_PACER    8'h24
`define ATSC_ADDR_STATUS   8'h28
`define ATSC_ADDR_CMD      8'h2C
`define ATSC_ADDR_SCANS    8'h30
// ctrl fields
`define ATSC_CTRL_ARM      0
`define ATSC_CTRL_MODE_LO  1
`define ATSC_CTRL_MODE_HI  2
`define ATSC_CTRL_CLK_LO   3
`define ATSC_CTRL_CLK_HI   4
`define ATSC_CTRL_MASTER   5
`define ATSC_CTRL_SLAVE    6
// trig fields
`define ATSC_TRG_SRC_LO    0
`define ATSC_TRG_SRC_HI    2
`define ATSC_TRG_POL       3
`define ATSC_TRG_EDGE      4
`define ATSC_TRG_CMP_LO    5
`define ATSC_TRG_CMP_HI    6
`define ATSC_TRG_STOP_LO   8
`define ATSC_TRG_STOP_HI   10
`define ATSC_TRG_CH_LO     16
`define ATSC_TRG_CH_HI     19
`define ATSC_TRG_PORT_LO   20
`define ATSC_TRG_PORT_HI   21
`define ATSC_TRG_CNT_LO    24
`define ATSC_TRG_CNT_HI    25
// cmd bits
`define ATSC_CMD_HALT      0
`define ATSC_CMD_STOPEV    1
`define ATSC_CMD_SWTRIG    2
// reset values
`define ATSC_RST_DIV       16'h0001
`define ATSC_RST_PACER     32'h000000C8
// latency bound in ns and its derived cycle count at 200 MHz
`define ATSC_LAT_NS        5000
`define ATSC_CLK_MHZ       200
`define ATSC_LAT_CYC       ((`ATSC_LAT_NS * `ATSC_CLK_MHZ) / 1000)
`endif

// *** atsc_pkg.sv ***
package atsc_pkg;
    typedef enum logic [1:0] {ATSC_IDLE, ATSC_PRE, ATSC_WAIT, ATSC_RUN} atsc_state_e;
    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0] sel;
        logic we;
        logic cyc;
        logic stb;
    } atsc_wb_req_s;
    typedef struct packed {
        logic [31:0] dat;
        logic ack;
    } atsc_wb_rsp_s;
    typedef struct packed {
        logic scan_clk;
        logic trig;
    } atsc_sync_s;
endpackage

// *** atsc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atsc_regs.svh"
// How it works
// - analog channel compared to level, fires on chosen rising or falling crossing
// - analog trigger reaches acquire start within a few cycles, well under 5us
// - discrete trigger input fires on high, low, rising or falling
// - discrete trigger starts acquisition within a few cycles, under 5us
// - unmasked bits of chosen digital port matched against pattern start scanning
// - chosen counter fires when reaching, exceeding or within a level window
// - no-pretrigger stop-event mode runs from trigger until stop event
// - fixed pretrigger stop mode collects pretrigger count then runs to stop
// - no-pretrigger infinite mode runs from trigger until halt command
// - fixed pretrigger infinite mode collects count then runs to halt
// - any trigger source is selectable as the stop event
// - sync slave or master mode forces post-trigger only operation
// - scan pacing from internal pacer, external pacer or sync clock input
// - dividers on sync clock input and external pacer input
// - master drives trigger and scan timing to sync port, uses its local trigger inputs
// - master forwards active scan clock onto sync connector
// - slave takes scan period from sync port clock
// - slave routes its discrete trigger from sync port trigger
module atsc_top #(
    parameter int ACH = 16,
    parameter int AW = 16,
    parameter int DW = 16,
    parameter int NCNT = 4
) (
    // clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // wishbone slave
    input wire atsc_pkg::atsc_wb_req_s wb_i,
    output atsc_pkg::atsc_wb_rsp_s wb_o,
    // trigger and external pacer inputs
    input wire logic [ACH*AW-1:0] analog_i,
    input wire logic discrete_trigger_input_i,
    input wire logic [4*DW-1:0] dig_port_i,
    input wire logic [NCNT*16-1:0] counter_i,
    input wire logic ext_pacer_i,
    // sync ports
    input wire atsc_pkg::atsc_sync_s sync_i,
    output atsc_pkg::atsc_sync_s sync_o,
    output atsc_pkg::atsc_sync_s sync_oe_o,
    // acquisition control to sequencer
    output logic acquire_o,
    output logic scan_start_o,
    output logic pre_phase_o
);
    import atsc_pkg::*;

    // select fields and 32-bit registers cannot reach beyond these sizes
    generate
        if (ACH < 1 || ACH > 16 || AW < 1 || AW > 32 || DW < 1 || DW > 32
            || NCNT < 1 || NCNT > 4) begin : g_bad_param
            $error("atsc_top: unsupported parameter");
        end
    endgenerate

    typedef struct packed {
        logic ack;
        logic [31:0] rdat;
        logic [6:0] ctrl;
        logic [31:0] trig;
        logic [31:0] alevel;
        logic [31:0] pattern;
        logic [31:0] mask;
        logic [15:0] clevel;
        logic [15:0] chigh;
        logic [15:0] precnt;
        logic [15:0] div;
        logic [31:0] pacer;
        atsc_state_e state;
        logic [15:0] pre_left;
        logic [31:0] pacer_cnt;
        logic [15:0] ext_cnt;
        logic [15:0] sync_cnt;
        logic ext_d;
        logic sync_clk_d;
        logic dtrig_d;
        logic above_d;
        logic cond_d;
        logic scan;
        logic tick_hold;
        logic [31:0] scans;
        logic fired;
        logic stopped;
        logic halt_p;
        logic stop_p;
        logic sw_p;
    } atsc_state_s;

    atsc_state_s q, d;

    ////////////////////////////////////////////////////////////////////
    // combinational views
    logic [AW-1:0] ach_val;
    logic [DW-1:0] dport_val;
    logic [15:0] cnt_val;
    logic [AW-1:0] ach_arr [ACH];
    logic [DW-1:0] dport_arr [4];
    logic [15:0] cnt_arr [NCNT];

    // unpack buses into indexable arrays
    genvar gi;
    generate
        for (gi = 0; gi < ACH; gi++) begin : g_ach
            assign ach_arr[gi] = analog_i[gi*AW +: AW];
        end
        for (gi = 0; gi < 4; gi++) begin : g_dp
            assign dport_arr[gi] = dig_port_i[gi*DW +: DW];
        end
        for (gi = 0; gi < NCNT; gi++) begin : g_cn
            assign cnt_arr[gi] = counter_i[gi*16 +: 16];
        end
    endgenerate

    logic [3:0] ach_sel;
    logic [1:0] port_sel;
    logic [1:0] cnt_sel;
    assign ach_sel = q.trig[`ATSC_TRG_CH_HI:`ATSC_TRG_CH_LO];
    assign port_sel = q.trig[`ATSC_TRG_PORT_HI:`ATSC_TRG_PORT_LO];
    assign cnt_sel = q.trig[`ATSC_TRG_CNT_HI:`ATSC_TRG_CNT_LO];
    // out-of-range selects fall back to channel zero
    assign ach_val = (32'(ach_sel) < ACH) ? ach_arr[ach_sel] : ach_arr[0];
    assign dport_val = dport_arr[port_sel];
    assign cnt_val = (32'(cnt_sel) < NCNT) ? cnt_arr[cnt_sel] : cnt_arr[0];

    ////////////////////////////////////////////////////////////////////
    // trigger condition evaluation
    logic above;
    logic dtrig_src;
    logic discrete_hit;
    logic analog_hit;
    logic pattern_hit;
    logic counter_hit;
    logic [7:0] src_hit;
    logic sync_mode;

    assign sync_mode = q.ctrl[`ATSC_CTRL_MASTER] | q.ctrl[`ATSC_CTRL_SLAVE];

    always_comb begin
        above = ach_val >= q.alevel[AW-1:0];
        analog_hit = q.trig[`ATSC_TRG_POL] ? (above & ~q.above_d) : (~above & q.above_d);
        dtrig_src = q.ctrl[`ATSC_CTRL_SLAVE] ? sync_i.trig : discrete_trigger_input_i;
        if (q.trig[`ATSC_TRG_EDGE]) begin
            discrete_hit = q.trig[`ATSC_TRG_POL] ? (dtrig_src & ~q.dtrig_d)
                                                 : (~dtrig_src & q.dtrig_d);
        end else begin
            discrete_hit = q.trig[`ATSC_TRG_POL] ? dtrig_src : ~dtrig_src;
        end
        pattern_hit = ((dport_val ^ q.pattern[DW-1:0]) & ~q.mask[DW-1:0]) == '0;
        case (q.trig[`ATSC_TRG_CMP_HI:`ATSC_TRG_CMP_LO])
            2'h0: counter_hit = cnt_val == q.clevel;
            2'h1: counter_hit = cnt_val > q.clevel;
            2'h2: counter_hit = (cnt_val >= q.clevel) && (cnt_val <= q.chigh);
            default: counter_hit = cnt_val >= q.clevel;
        endcase
        src_hit = {3'h0, q.sw_p, counter_hit, pattern_hit, discrete_hit, analog_hit};
    end

    logic start_hit;
    logic stop_hit;
    // stop source picked from same set
    assign stop_hit = src_hit[q.trig[`ATSC_TRG_STOP_HI:`ATSC_TRG_STOP_LO]] | q.stop_p;
    assign start_hit = src_hit[q.trig[`ATSC_TRG_SRC_HI:`ATSC_TRG_SRC_LO]];

    ////////////////////////////////////////////////////////////////////
    // scan clock selection and dividers
    logic ext_rise;
    logic sync_rise;
    logic ext_tick;
    logic sync_tick;
    logic pacer_tick;
    logic scan_tick;
    assign ext_rise = ext_pacer_i & ~q.ext_d;
    assign sync_rise = sync_i.scan_clk & ~q.sync_clk_d;
    assign ext_tick = ext_rise && (q.ext_cnt + 16'h0001 >= q.div);
    assign sync_tick = sync_rise && (q.sync_cnt + 16'h0001 >= q.div);
    assign pacer_tick = q.pacer_cnt + 32'h00000001 >= q.pacer;

    always_comb begin
        if (q.ctrl[`ATSC_CTRL_SLAVE]) begin
            scan_tick = sync_tick;
        end else begin
            case (q.ctrl[`ATSC_CTRL_CLK_HI:`ATSC_CTRL_CLK_LO])
                2'h0: scan_tick = pacer_tick;
                2'h1: scan_tick = ext_tick;
                2'h2: scan_tick = sync_tick;
                default: scan_tick = pacer_tick;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    logic wr;
    logic rd;
    logic [31:0] wmask;
    logic [1:0] mode;
    logic pre_mode;
    logic stop_mode;
    assign wr = wb_i.cyc & wb_i.stb & wb_i.we & ~q.ack;
    assign rd = wb_i.cyc & wb_i.stb & ~wb_i.we & ~q.ack;
    assign wmask = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
    assign mode = q.ctrl[`ATSC_CTRL_MODE_HI:`ATSC_CTRL_MODE_LO];
    // sync operation drops the pre-trigger phase
    assign pre_mode = mode[1] & ~sync_mode;
    assign stop_mode = ~mode[0];

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [31:0] m);
        merge = (old & ~m) | (nw & m);
    endfunction

    always_comb begin
        d = q;
        d.ack = (wb_i.cyc & wb_i.stb) & ~q.ack;
        d.halt_p = 1'b0;
        d.stop_p = 1'b0;
        d.sw_p = 1'b0;
        d.ext_d = ext_pacer_i;
        d.sync_clk_d = sync_i.scan_clk;
        d.dtrig_d = dtrig_src;
        d.above_d = above;
        d.scan = 1'b0;
        // divider and pacer counters
        if (ext_rise) begin
            d.ext_cnt = ext_tick ? 16'h0000 : q.ext_cnt + 16'h0001;
        end
        if (sync_rise) begin
            d.sync_cnt = sync_tick ? 16'h0000 : q.sync_cnt + 16'h0001;
        end
        d.pacer_cnt = pacer_tick ? 32'h00000000 : q.pacer_cnt + 32'h00000001;
        d.tick_hold = scan_tick;
        // bus writes
        if (wr) begin
            case (wb_i.adr[7:0])
                `ATSC_ADDR_CTRL: d.ctrl = 7'(merge({25'h0, q.ctrl}, wb_i.dat, wmask));
                `ATSC_ADDR_TRIG: d.trig = merge(q.trig, wb_i.dat, wmask);
                `ATSC_ADDR_ALEVEL: d.alevel = merge(q.alevel, wb_i.dat, wmask);
                `ATSC_ADDR_PATTERN: d.pattern = merge(q.pattern, wb_i.dat, wmask);
                `ATSC_ADDR_MASK: d.mask = merge(q.mask, wb_i.dat, wmask);
                `ATSC_ADDR_CLEVEL: d.clevel = 16'(merge({16'h0, q.clevel}, wb_i.dat, wmask));
                `ATSC_ADDR_CHIGH: d.chigh = 16'(merge({16'h0, q.chigh}, wb_i.dat, wmask));
                `ATSC_ADDR_PRECNT: d.precnt = 16'(merge({16'h0, q.precnt}, wb_i.dat, wmask));
                `ATSC_ADDR_DIV: d.div = 16'(merge({16'h0, q.div}, wb_i.dat, wmask));
                `ATSC_ADDR_PACER: d.pacer = merge(q.pacer, wb_i.dat, wmask);
                `ATSC_ADDR_CMD: begin
                    d.halt_p = wb_i.sel[0] & wb_i.dat[`ATSC_CMD_HALT];
                    d.stop_p = wb_i.sel[0] & wb_i.dat[`ATSC_CMD_STOPEV];
                    d.sw_p = wb_i.sel[0] & wb_i.dat[`ATSC_CMD_SWTRIG];
                end
                default: ;
            endcase
        end
        // acquisition sequencing
        case (q.state)
            ATSC_IDLE: begin
                if (q.ctrl[`ATSC_CTRL_ARM] && !q.fired) begin
                    d.scans = 32'h00000000;
                    d.stopped = 1'b0;
                    d.pre_left = q.precnt;
                    d.state = pre_mode ? ATSC_PRE : ATSC_WAIT;
                end
            end
            ATSC_PRE: begin
                if (scan_tick) begin
                    d.scan = 1'b1;
                    d.scans = q.scans + 32'h00000001;
                    d.pre_left = q.pre_left - 16'h0001;
                    if (q.pre_left <= 16'h0001) begin
                        d.state = ATSC_WAIT;
                    end
                end
                if (q.pre_left == 16'h0000) begin
                    d.state = ATSC_WAIT;
                end
            end
            ATSC_WAIT: begin
                if (pre_mode && scan_tick) begin
                    d.scan = 1'b1;
                    d.scans = q.scans + 32'h00000001;
                end
                if (start_hit) begin
                    d.fired = 1'b1;
                    d.state = ATSC_RUN;
                end
            end
            ATSC_RUN: begin
                if (scan_tick) begin
                    d.scan = 1'b1;
                    d.scans = q.scans + 32'h00000001;
                end
                if ((stop_mode && stop_hit) || q.halt_p) begin
                    d.stopped = 1'b1;
                    d.state = ATSC_IDLE;
                end
            end
            default: d.state = ATSC_IDLE;
        endcase
        if (q.halt_p && q.state != ATSC_RUN) begin
            d.state = ATSC_IDLE;
        end
        // disarm rearms for the next acquisition
        if (!q.ctrl[`ATSC_CTRL_ARM]) begin
            d.fired = 1'b0;
            d.state = ATSC_IDLE;
        end
        // bus reads
        d.rdat = 32'h00000000;
        if (rd) begin
            case (wb_i.adr[7:0])
                `ATSC_ADDR_CTRL: d.rdat = {25'h0, q.ctrl};
                `ATSC_ADDR_TRIG: d.rdat = q.trig;
                `ATSC_ADDR_ALEVEL: d.rdat = q.alevel;
                `ATSC_ADDR_PATTERN: d.rdat = q.pattern;
                `ATSC_ADDR_MASK: d.rdat = q.mask;
                `ATSC_ADDR_CLEVEL: d.rdat = {16'h0, q.clevel};
                `ATSC_ADDR_CHIGH: d.rdat = {16'h0, q.chigh};
                `ATSC_ADDR_PRECNT: d.rdat = {16'h0, q.precnt};
                `ATSC_ADDR_DIV: d.rdat = {16'h0, q.div};
                `ATSC_ADDR_PACER: d.rdat = q.pacer;
                `ATSC_ADDR_STATUS: d.rdat = {26'h0, q.stopped, q.fired, 2'(q.state),
                                             src_hit[1:0]};
                `ATSC_ADDR_SCANS: d.rdat = q.scans;
                default: d.rdat = 32'h00000000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register; ce_i low freezes everything
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q <= '0;
            q.state <= ATSC_IDLE;
            q.div <= `ATSC_RST_DIV;
            q.pacer <= `ATSC_RST_PACER;
        end else if (ce_i) begin
            q <= d;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // outputs
    assign wb_o.ack = q.ack;
    assign wb_o.dat = q.rdat;
    assign acquire_o = (q.state == ATSC_RUN);
    assign scan_start_o = q.scan;
    assign pre_phase_o = (q.state == ATSC_PRE) || (q.state == ATSC_WAIT && pre_mode);
    assign sync_o.scan_clk = q.ctrl[`ATSC_CTRL_MASTER] & q.tick_hold;
    assign sync_o.trig = q.ctrl[`ATSC_CTRL_MASTER] & q.fired;
    assign sync_oe_o.scan_clk = q.ctrl[`ATSC_CTRL_MASTER];
    assign sync_oe_o.trig = q.ctrl[`ATSC_CTRL_MASTER];
endmodule // atsc_top
`default_nettype wire

// *** atsc_peer.sv ***
`timescale 1ns/1ps
`default_nettype none
module atsc_peer #(
    parameter int PERIOD = 1001
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // bench control
    input wire logic en_i,
    input wire logic trig_i,
    // sync port side
    output atsc_pkg::atsc_sync_s sync_o,
    output atsc_pkg::atsc_sync_s sync_oe_o
);
    import atsc_pkg::*;
    int cnt;
    // dead time kept
    // one short tick per period; 1000 idle cycles at 5 ns make the 5 us dead time
    always_ff @(posedge clk_i) begin
        if (rst_i || !en_i) begin
            cnt <= 0;
            sync_o <= '0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            sync_o.scan_clk <= (cnt == 0);
            sync_o.trig <= trig_i;
        end
    end
    // released lines fall to the pull-down level, so outputs go to zero too
    assign sync_oe_o = {en_i, en_i};
endmodule // atsc_peer
`default_nettype wire

// *** atsc_top_chk.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atsc_regs.svh"
module atsc_chk (
    // clock, reset and enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // register bus
    input wire atsc_pkg::atsc_wb_req_s wb_i,
    input wire atsc_pkg::atsc_wb_rsp_s wb_o,
    // sync port and acquisition
    input wire atsc_pkg::atsc_sync_s sync_o,
    input wire atsc_pkg::atsc_sync_s sync_oe_o,
    input wire logic acquire_o,
    input wire logic pre_phase_o
);
    import atsc_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // a request the slave takes at this edge
    sequence bus_take;
        wb_i.cyc && wb_i.stb && !wb_o.ack && ce_i;
    endsequence
    sequence ack_once;
        wb_o.ack ##1 !wb_o.ack;
    endsequence
    sequence halt_take;
        bus_take ##0 (wb_i.we && wb_i.adr[7:0] == `ATSC_ADDR_CMD && wb_i.dat[0]);
    endsequence
    // bus answer timing
    ack_answer_a: assert property (bus_take |=> ack_once)
        else $error("bus request not answered by a single ack");
    rdat_idle_a: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
        else $error("read data not zero outside ack");
    // sync port ownership
    oe_pair_a: assert property (sync_oe_o.scan_clk == sync_oe_o.trig)
        else $error("sync enables differ");
    trig_oe_a: assert property (sync_o.trig |-> sync_oe_o.trig)
        else $error("sync trigger high while not driven");
    clk_oe_a: assert property (sync_o.scan_clk |-> sync_oe_o.scan_clk)
        else $error("sync scan tick while not driven");
    master_post_a: assert property (sync_oe_o.trig |-> !pre_phase_o)
        else $error("pretrigger phase while sync master");
    // acquisition phases
    pre_idle_a: assert property (pre_phase_o |-> !acquire_o)
        else $error("acquiring during pretrigger phase");
    halt_drop_a: assert property (halt_take |-> ##[1:4] !acquire_o)
        else $error("halt did not stop acquisition");
endmodule // atsc_chk
bind atsc_top atsc_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_i(wb_i),
    .wb_o(wb_o), .sync_o(sync_o), .sync_oe_o(sync_oe_o), .acquire_o(acquire_o),
    .pre_phase_o(pre_phase_o));
`default_nettype wire

// *** tb_acquisition_trigger_sync_control.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "atsc_regs.svh"
module tb_acquisition_trigger_sync_control;
    import atsc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    atsc_wb_req_s wb = '0;
    atsc_wb_rsp_s wbr;
    logic [255:0] ana = '0;
    logic disc = 1'b0;
    logic [63:0] dig = '0;
    logic [63:0] cnt = '0;
    logic peer_en = 1'b0;
    logic peer_trig = 1'b0;
    logic ce = 1'b1;
    logic ext_pac = 1'b0;
    int n_scan = 0;
    int scan_base = 0;
    // 1000 idle cycles at 5 ns give each slave scan the 5 us dead time
    localparam int SYNC_PER = 1001;
    atsc_sync_s s_dut, oe_dut, s_peer, oe_peer, s_wire;
    logic acq, scan, pre;
    int bad_count = 0;
    int n_checks = 0;
    logic [15:0] hv [4] = '{16'h0050, 16'h0051, 16'h0055, 16'h0050};
    // shared sync lines with pull-downs: an undriven line reads low
    assign s_wire = (s_dut & oe_dut) | (s_peer & oe_peer);
    initial forever #2.5 clk_i = ~clk_i;
    // free-running external pacer: one rising edge every two cycles
    always @(posedge clk_i) ext_pac <= ~ext_pac;
    // scans seen on the pin, for matching against the scan counter
    always @(posedge clk_i) begin
        if (scan === 1'b1) n_scan <= n_scan + 1;
    end
    atsc_top dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_i(wb), .wb_o(wbr),
        .analog_i(ana), .discrete_trigger_input_i(disc), .dig_port_i(dig), .counter_i(cnt),
        .ext_pacer_i(ext_pac), .sync_i(s_wire), .sync_o(s_dut), .sync_oe_o(oe_dut),
        .acquire_o(acq), .scan_start_o(scan), .pre_phase_o(pre));
    atsc_peer #(.PERIOD(SYNC_PER)) peer (.clk_i(clk_i), .rst_i(rst_i), .en_i(peer_en),
        .trig_i(peer_trig), .sync_o(s_peer), .sync_oe_o(oe_peer));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic cycle: hold the request until ack is seen at an edge;
    // only the watchdog ends a wait that never sees ack
    task automatic wb_acc(input logic we, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
        wb <= '{adr: {24'h0, a}, dat: d, sel: 4'hF, we: we, cyc: 1'b1, stb: 1'b1};
        do begin
            @(posedge clk_i);
        end while (wbr.ack !== 1'b1);
        q = wbr.dat;
        wb <= '0;
        @(posedge clk_i);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb_acc(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb_acc(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task automatic wait_acq(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && acq !== v; i++) @(posedge clk_i);
        chk({31'h0, acq}, {31'h0, v});
    endtask
    // counts scan starts (sel 0) or forwarded sync ticks (sel 1)
    task automatic count(input bit sel, input int len, input int exp);
        int n;
        n = 0;
        repeat (len) begin
            @(posedge clk_i);
            if ((sel ? s_dut.scan_clk : scan) === 1'b1) n++;
        end
        chk(n, exp);
    endtask
    // drives one trigger source: 0 analog ch3, 1 discrete, 2 port 1, 3 counter 2
    task automatic put(input int k, input logic [15:0] v);
        case (k)
            0: ana[48 +: 16] <= v;
            1: disc <= v[0];
            2: dig[16 +: 16] <= v;
            default: cnt[32 +: 16] <= v;
        endcase
        @(posedge clk_i);
    endtask
    // arm in halt mode, prove quiet on idle input, fire in time, then halt
    task automatic trial(input logic [31:0] trg, input int k, input logic [15:0] idle,
                         input logic [15:0] hit);
        put(k, idle);
        wr(`ATSC_ADDR_TRIG, trg);
        wr(`ATSC_ADDR_CTRL, 32'h3);
        repeat (4) @(posedge clk_i);
        chk({31'h0, acq}, 32'h0);
        put(k, hit);
        wait_acq(1'b1, `ATSC_LAT_CYC);
        wr(`ATSC_ADDR_CMD, 32'h1);
        wait_acq(1'b0, 8);
        wr(`ATSC_ADDR_CTRL, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // watchdog sized well above the twenty thousand or so cycles the tests need
    initial begin
        #250000;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rd(`ATSC_ADDR_DIV, 32'h1);
        rd(`ATSC_ADDR_PACER, 32'hC8);
        rd(8'h40, 32'h0);
        wr(`ATSC_ADDR_PRECNT, 32'h3);
        rd(`ATSC_ADDR_PRECNT, 32'h3);
        wr(`ATSC_ADDR_PACER, 32'h4);
        $display("registers test done");
        for (int m = 0; m < 4; m++) trial(32'h1 | (m << 3), 1, 16'(!m[0]), 16'(m[0]));
        wr(`ATSC_ADDR_ALEVEL, 32'h100);
        trial(32'h0003_0008, 0, 16'h00FF, 16'h0100);
        wr(`ATSC_ADDR_PATTERN, 32'hA5);
        wr(`ATSC_ADDR_MASK, 32'hFF00);
        trial(32'h0010_0002, 2, 16'h33A4, 16'h77A5);
        wr(`ATSC_ADDR_CLEVEL, 32'h50);
        wr(`ATSC_ADDR_CHIGH, 32'h60);
        for (int c = 0; c < 4; c++) trial(32'h0200_0003 | (c << 5), 3, 16'h10, hv[c]);
        $display("trigger sources test done");
        // start on a discrete edge, stop on a counter level
        put(3, 16'h10);
        put(1, 16'h0);
        wr(`ATSC_ADDR_TRIG, 32'h0200_0379);
        wr(`ATSC_ADDR_CTRL, 32'h1);
        put(1, 16'h1);
        wait_acq(1'b1, `ATSC_LAT_CYC);
        repeat (8) @(posedge clk_i);
        chk({31'h0, acq}, 32'h1);
        put(3, 16'h50);
        wait_acq(1'b0, `ATSC_LAT_CYC);
        wr(`ATSC_ADDR_CTRL, 32'h0);
        $display("stop event test done");
        // fixed pretrigger with command trigger and command stop
        wr(`ATSC_ADDR_TRIG, 32'h4);
        scan_base = n_scan;
        wr(`ATSC_ADDR_CTRL, 32'h5);
        repeat (4) @(posedge clk_i);
        chk({30'h0, pre, acq}, 32'h2);
        repeat (20) @(posedge clk_i);
        wr(`ATSC_ADDR_CMD, 32'h4);
        wait_acq(1'b1, `ATSC_LAT_CYC);
        chk({31'h0, pre}, 32'h0);
        wr(`ATSC_ADDR_CMD, 32'h2);
        wait_acq(1'b0, 8);
        rd(`ATSC_ADDR_STATUS, 32'h30);
        rd(`ATSC_ADDR_SCANS, 32'(n_scan - scan_base));
        wr(`ATSC_ADDR_CTRL, 32'h0);
        // zero pretrigger fill: trigger taken at once, stop event ignored, halt ends it
        wr(`ATSC_ADDR_PRECNT, 32'h0);
        wr(`ATSC_ADDR_CTRL, 32'h7);
        wr(`ATSC_ADDR_CMD, 32'h4);
        wait_acq(1'b1, 8);
        wr(`ATSC_ADDR_CMD, 32'h2);
        chk({31'h0, acq}, 32'h1);
        wr(`ATSC_ADDR_CMD, 32'h1);
        wait_acq(1'b0, 8);
        wr(`ATSC_ADDR_CTRL, 32'h0);
        $display("pretrigger test done");
        // master: fixed pretrigger asked for, post-trigger only delivered
        put(1, 16'h0);
        wr(`ATSC_ADDR_TRIG, 32'h19);
        wr(`ATSC_ADDR_CTRL, 32'h27);
        chk({30'h0, oe_dut}, 32'h3);
        chk({31'h0, pre}, 32'h0);
        count(1'b1, 40, 10);
        wr(`ATSC_ADDR_CTRL, 32'h2F);
        count(1'b1, 40, 20);
        // a frozen block must not see the trigger edge until enabled again
        ce <= 1'b0;
        put(1, 16'h1);
        repeat (8) @(posedge clk_i);
        chk({31'h0, acq}, 32'h0);
        ce <= 1'b1;
        wait_acq(1'b1, `ATSC_LAT_CYC);
        repeat (2) @(posedge clk_i);
        chk({31'h0, s_dut.trig}, 32'h1);
        wr(`ATSC_ADDR_CMD, 32'h1);
        wr(`ATSC_ADDR_CTRL, 32'h0);
        $display("master test done");
        // slave: trigger and pacing come from the peer, local input driven high and ignored
        put(1, 16'h0);
        wr(`ATSC_ADDR_CTRL, 32'h43);
        chk({30'h0, oe_dut}, 32'h0);
        peer_en <= 1'b1;
        put(1, 16'h1);
        repeat (12) @(posedge clk_i);
        chk({31'h0, acq}, 32'h0);
        peer_trig <= 1'b1;
        wait_acq(1'b1, `ATSC_LAT_CYC);
        count(1'b0, 10 * SYNC_PER, 10);
        wr(`ATSC_ADDR_DIV, 32'h2);
        count(1'b0, 10 * SYNC_PER, 5);
        wr(`ATSC_ADDR_CMD, 32'h1);
        wait_acq(1'b0, 8);
        peer_en <= 1'b0;
        $display("slave test done");
        end_of_test();
    end
endmodule // tb_acquisition_trigger_sync_control
`default_nettype wire
